//--- rtl/cef_defs.svh
`ifndef CEF_DEFS_SVH
`define CEF_DEFS_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define CEF_OFS_FLAGS    6'h00
`define CEF_OFS_GMASK    6'h04
`define CEF_OFS_MBMASK   6'h08
`define CEF_OFS_STATUS   6'h0c
`define CEF_OFS_MCTRL    6'h10
`define CEF_OFS_TXREQ    6'h14
`define CEF_OFS_TXCAN    6'h18
`define CEF_OFS_TEC      6'h1c
`define CEF_OFS_REC      6'h20
`define CEF_OFS_STOP     6'h24

// ********************************************************
// Flag bit positions
// ********************************************************
`define CEF_F_RESET      0
`define CEF_F_RXMSG      1
`define CEF_F_REMOTE     2
`define CEF_F_TXWARN     3
`define CEF_F_RXWARN     4
`define CEF_F_PASSIVE    5
`define CEF_F_BUSOFF     6
`define CEF_F_OVERLOAD   7
`define CEF_F_TXDONE     8
`define CEF_F_OVERWRITE  9
`define CEF_F_SLEEPACT   12
`define CEF_FLAG_IMPL    16'h13ff

// ********************************************************
// Status and control bit positions
// ********************************************************
`define CEF_S_BUSOFF     0
`define CEF_S_WARN       1
`define CEF_S_PASSIVE    2
`define CEF_S_RESET      3
`define CEF_C_SWRESET    0
`define CEF_C_SLEEP      5
`define CEF_STOP_BIT     0

// ********************************************************
// Reset values
// ********************************************************
`define CEF_RST_FLAGS    16'h0001
`define CEF_RST_GMASK    16'hffff
`define CEF_RST_MBMASK   16'hffff
`define CEF_RST_SWRESET  1'b1
`define CEF_RST_STOP     1'b1

// ********************************************************
// Error counter thresholds
// ********************************************************
`define CEF_WARN_LIMIT   9'h060
`define CEF_PASS_LIMIT   9'h080
`define CEF_BUSOFF_LIMIT 9'h100
`define CEF_TEC_STEP     9'h008
`define CEF_REC_MAX      8'hff
`define CEF_RECOVER_SEQ  8'h80

`endif

//--- rtl/cef_pkg.sv
package cef_pkg;

    typedef struct packed {
        logic       tx_err;
        logic       tx_ok;
        logic       rx_err;
        logic       rx_ok;
        logic       rec11;
    } cef_err_evt_t;

    typedef struct packed {
        logic [8:0] tec;
        logic [7:0] rec;
        logic       bus_off;
    } cef_err_cnt_t;

    typedef struct packed {
        logic         rx_valid;
        logic         rx_remote;
        logic [3:0]   rx_mb;
        logic         ovw_valid;
        logic         tx_done;
        logic [3:0]   tx_mb;
        logic [15:0]  tx_busy;
        logic         overload;
        logic         bus_idle;
        cef_err_evt_t err;
    } cef_eng_evt_t;

    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] gmask;
        logic [15:0] mbmask;
        logic [15:0] txreq;
        logic [15:0] txcan;
        logic        sw_reset;
        logic        sleep_req;
        logic        sleep_act;
        logic        stop;
        logic        tw_seen;
        logic        rw_seen;
        logic        ep_seen;
        logic        bo_seen;
        logic        rxpin_q;
        logic        swstb_q;
        logic        irq;
        logic        waitreq;
        logic [31:0] rdata;
    } cef_state_t;

endpackage

//--- rtl/cef_err_cnt.sv
`timescale 1ns/10ps
`include "cef_defs.svh"

module cef_err_cnt
    import cef_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire cef_err_evt_t evt,
    output cef_err_cnt_t      cnt
);

    cef_err_cnt_t s_r;
    cef_err_cnt_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (clear)
        begin
            s_nxt = '0;
        end
        else if (s_r.bus_off)
        begin
            if (evt.rec11)
            begin
                if (s_r.rec == (`CEF_RECOVER_SEQ - 8'h01))
                begin
                    s_nxt = '0;
                end
                else
                begin
                    s_nxt.rec = s_r.rec + 8'h01;
                end
            end
        end
        else
        begin
            if (evt.tx_err)
            begin
                if (s_r.tec >= (`CEF_BUSOFF_LIMIT - `CEF_TEC_STEP))
                    s_nxt.tec = `CEF_BUSOFF_LIMIT;
                else
                    s_nxt.tec = s_r.tec + `CEF_TEC_STEP;
            end
            else if (evt.tx_ok && s_r.tec != 9'h000)
            begin
                s_nxt.tec = s_r.tec - 9'h001;
            end
            if (evt.rx_err && s_r.rec != `CEF_REC_MAX)
            begin
                s_nxt.rec = s_r.rec + 8'h01;
            end
            else if (evt.rx_ok && s_r.rec != 8'h00)
            begin
                s_nxt.rec = s_r.rec - 8'h01;
            end
            if (s_nxt.tec >= `CEF_BUSOFF_LIMIT)
            begin
                s_nxt.bus_off = 1'b1;
                s_nxt.rec     = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign cnt = s_r;

endmodule // cef_err_cnt

//--- rtl/cef_ctrl.sv
// Operation
// - Error-passive flag sets when either error counter reaches 128.
// - Bus-off flag sets when the transmit error counter reaches 256.
// - Transmit warning flag sets when transmit counter reaches 96.
// - Receive warning flag sets when receive counter reaches 96.
// - Global and mailbox masks gate every source except reset-process flag.
// - Separate flags for remote frame, overload, overwrite, sleep bus activity.
// - Reception into any mailbox sets one shared receive flag.
// - Transmit completion or cancellation sets one shared flag.
// - Masked mailbox events set no receive, remote or transmit flag.
// - Resets and standby initialise registers; mailbox storage untouched.
// - Reset-process flag set after power-on or software standby; software clears.
// - Reset-status bit reads set while in sleep.
// - Counters step normally in error-active and error-passive.
// - In bus-off, receive counter counts 11-recessive runs; 96 warns.
// - Byte and word accesses only; longword accesses refused.
// - No register access in medium-speed mode.
// - Flags clear on write of one; zero bits leave flags alone.
// - Module stop set after reset; registers reachable once cleared.
// - Cancel requests have no effect during bus-off.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "cef_defs.svh"

module cef_ctrl
    import cef_pkg::*;
#(
    parameter int NUM_MB = 16
)
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [5:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    input  wire logic [3:0]   avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    input  wire logic         medium_speed,
    input  wire logic         hw_standby,
    input  wire logic         sw_standby,
    input  wire logic         can_receive_pin,
    input  wire cef_eng_evt_t eng,
    output logic [15:0]       tx_request,
    output logic              halted,
    output logic              sleep_active,
    output logic              irq
);

    // ********************************************************
    // Elaboration checks
    // ********************************************************
    generate
        if (NUM_MB < 1 || NUM_MB > 16)
        begin : g_bad_mb
            $error("NUM_MB must lie between 1 and 16");
        end
    endgenerate

    localparam logic [16:0] MB_ONE  = 17'h00001;
    localparam logic [16:0] MB_FULL = (MB_ONE << NUM_MB) - MB_ONE;
    localparam logic [15:0] MB_MASK = MB_FULL[15:0];

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic legal_be(input logic [3:0] be);
        legal_be = (be == 4'h1) || (be == 4'h2) || (be == 4'h4) ||
                   (be == 4'h8) || (be == 4'h3) || (be == 4'hc);
    endfunction

    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [3:0]  be);
        logic [15:0] m;
        m     = lane_mask(be);
        merge = (old & ~m) | (val & m);
    endfunction

    function automatic cef_state_t init_state(input cef_state_t cur);
        cef_state_t s;
        s           = '0;
        s.flags     = `CEF_RST_FLAGS;
        s.gmask     = `CEF_RST_GMASK;
        s.mbmask    = `CEF_RST_MBMASK;
        s.sw_reset  = `CEF_RST_SWRESET;
        s.stop      = cur.stop;
        s.rxpin_q   = cur.rxpin_q;
        s.swstb_q   = cur.swstb_q;
        s.waitreq   = cur.waitreq;
        s.rdata     = cur.rdata;
        init_state  = s;
    endfunction

    // ********************************************************
    // Error counters
    // ********************************************************
    cef_state_t   s_r;
    cef_state_t   s_nxt;
    cef_err_cnt_t cnt;
    logic         cnt_clear;

    assign cnt_clear = s_r.stop | s_r.sw_reset | hw_standby | sw_standby;

    cef_err_cnt u_err_cnt (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (cnt_clear),
        .evt      (eng.err),
        .cnt      (cnt)
    );

    // ********************************************************
    // Next state
    // ********************************************************
    logic        req;
    logic        acc_ok;
    logic        wr;
    logic        rd;
    logic [15:0] wd;
    logic [15:0] w1c;
    logic [15:0] set;
    logic [15:0] cancel_now;
    logic [15:0] rval;
    logic        tw;
    logic        rw;
    logic        ep;
    logic        bo;
    logic [15:0] enabled;

    always_comb
    begin
        s_nxt      = s_r;
        set        = '0;
        w1c        = '0;
        rval       = '0;
        wd         = avs_writedata[15:0];
        s_nxt.waitreq = 1'b1;

        // One wait state per access; answer registered
        req = (avs_read | avs_write) & s_r.waitreq;
        // Medium speed and module stop block access
        acc_ok = !medium_speed && ((avs_address == `CEF_OFS_STOP) || !s_r.stop);
        // Longword or odd lane patterns refused
        wr = req & avs_write & legal_be(avs_byteenable) & acc_ok;
        rd = req & avs_read & legal_be(avs_byteenable) & acc_ok;

        unique case (avs_address)
            `CEF_OFS_FLAGS:  rval = s_r.flags;
            `CEF_OFS_GMASK:  rval = s_r.gmask;
            `CEF_OFS_MBMASK: rval = s_r.mbmask;
            `CEF_OFS_STATUS:
            begin
                rval[`CEF_S_BUSOFF]  = cnt.bus_off;
                rval[`CEF_S_WARN]    = (cnt.tec >= `CEF_WARN_LIMIT) ||
                                       ({1'b0, cnt.rec} >= `CEF_WARN_LIMIT);
                rval[`CEF_S_PASSIVE] = (cnt.tec >= `CEF_PASS_LIMIT) ||
                                       ({1'b0, cnt.rec} >= `CEF_PASS_LIMIT);
                rval[`CEF_S_RESET]   = s_r.sw_reset | s_r.sleep_act;
            end
            `CEF_OFS_MCTRL:
            begin
                rval[`CEF_C_SWRESET] = s_r.sw_reset;
                rval[`CEF_C_SLEEP]   = s_r.sleep_req;
            end
            `CEF_OFS_TXREQ:  rval = s_r.txreq;
            `CEF_OFS_TXCAN:  rval = s_r.txcan;
            `CEF_OFS_TEC:    rval = {7'h00, cnt.tec};
            `CEF_OFS_REC:    rval = {8'h00, cnt.rec};
            `CEF_OFS_STOP:   rval[`CEF_STOP_BIT] = s_r.stop;
            default:         rval = '0;
        endcase

        if (req)
        begin
            s_nxt.waitreq = 1'b0;
            s_nxt.rdata   = rd ? {16'h0000, rval} : 32'h0000_0000;
        end

        // Register writes
        if (wr)
        begin
            unique case (avs_address)
                `CEF_OFS_FLAGS:  w1c = wd & lane_mask(avs_byteenable);
                `CEF_OFS_GMASK:  s_nxt.gmask = merge(s_r.gmask, wd, avs_byteenable);
                `CEF_OFS_MBMASK: s_nxt.mbmask = merge(s_r.mbmask, wd, avs_byteenable);
                `CEF_OFS_MCTRL:
                begin
                    if (avs_byteenable[0])
                    begin
                        s_nxt.sw_reset  = wd[`CEF_C_SWRESET];
                        s_nxt.sleep_req = wd[`CEF_C_SLEEP];
                    end
                end
                `CEF_OFS_TXREQ:
                    s_nxt.txreq = s_r.txreq | (wd & lane_mask(avs_byteenable) & MB_MASK);
                `CEF_OFS_TXCAN:
                    s_nxt.txcan = s_r.txcan | (wd & lane_mask(avs_byteenable) & MB_MASK);
                `CEF_OFS_STOP:
                begin
                    if (avs_byteenable[0])
                        s_nxt.stop = wd[`CEF_STOP_BIT];
                end
                default:
                begin
                end
            endcase
        end

        // Shared receive flag; mailbox mask blocks it
        if (eng.rx_valid && !s_r.mbmask[eng.rx_mb])
        begin
            // Remote frame has its own flag
            if (eng.rx_remote)
                set[`CEF_F_REMOTE] = 1'b1;
            else
                set[`CEF_F_RXMSG] = 1'b1;
        end
        set[`CEF_F_OVERWRITE] = eng.ovw_valid;
        set[`CEF_F_OVERLOAD]  = eng.overload;

        // No cancel while bus-off; busy mailboxes cannot cancel
        cancel_now = s_r.txcan & s_r.txreq & ~eng.tx_busy & {16{~cnt.bus_off}};
        s_nxt.txreq = s_nxt.txreq & ~cancel_now;
        s_nxt.txcan = s_nxt.txcan & ~cancel_now;
        if (!cnt.bus_off)
            s_nxt.txcan = s_nxt.txcan & (s_r.txreq | ~s_r.txcan);
        if (eng.tx_done)
        begin
            s_nxt.txreq[eng.tx_mb] = 1'b0;
            s_nxt.txcan[eng.tx_mb] = 1'b0;
        end
        // One flag for completion or cancel; masked mailboxes excluded
        if ((eng.tx_done && !s_r.mbmask[eng.tx_mb]) || |(cancel_now & ~s_r.mbmask))
            set[`CEF_F_TXDONE] = 1'b1;

        // Level thresholds raise flags once per crossing
        tw = cnt.tec >= `CEF_WARN_LIMIT;
        rw = {1'b0, cnt.rec} >= `CEF_WARN_LIMIT;
        ep = (cnt.tec >= `CEF_PASS_LIMIT) || ({1'b0, cnt.rec} >= `CEF_PASS_LIMIT);
        bo = cnt.bus_off;
        set[`CEF_F_TXWARN]  = tw & ~s_r.tw_seen;
        // Receive warning, also reached bus-off counting
        set[`CEF_F_RXWARN]  = rw & ~s_r.rw_seen;
        set[`CEF_F_PASSIVE] = ep & ~s_r.ep_seen;
        set[`CEF_F_BUSOFF]  = bo & ~s_r.bo_seen;
        s_nxt.tw_seen = tw;
        s_nxt.rw_seen = rw;
        s_nxt.ep_seen = ep;
        s_nxt.bo_seen = bo;

        // Sleep waits for an idle bus before taking effect
        if (!s_nxt.sleep_req)
            s_nxt.sleep_act = 1'b0;
        else if (eng.bus_idle)
            s_nxt.sleep_act = 1'b1;
        set[`CEF_F_SLEEPACT] = s_r.sleep_act & s_r.rxpin_q & ~can_receive_pin;
        s_nxt.rxpin_q = can_receive_pin;

        // Recovery from software standby raises reset flag
        set[`CEF_F_RESET] = s_r.swstb_q & ~sw_standby;
        s_nxt.swstb_q = sw_standby;

        // Set wins over a simultaneous clear
        s_nxt.flags = ((s_r.flags & ~w1c) | set) & `CEF_FLAG_IMPL;

        // Standby and module stop initialise registers except module stop, pin and standby samples, and bus answer
        if (hw_standby || sw_standby || s_nxt.stop)
            s_nxt = init_state(s_nxt);

        // Interrupt from unmasked flags; reset flag unmaskable
        enabled = ~s_nxt.gmask;
        enabled[`CEF_F_RESET] = 1'b1;
        s_nxt.irq = |(s_nxt.flags & enabled);
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r          <= '0;
            s_r.flags    <= `CEF_RST_FLAGS;
            s_r.gmask    <= `CEF_RST_GMASK;
            s_r.mbmask   <= `CEF_RST_MBMASK;
            s_r.sw_reset <= `CEF_RST_SWRESET;
            // Halted by module stop out of reset
            s_r.stop     <= `CEF_RST_STOP;
            s_r.rxpin_q  <= 1'b1;
            s_r.irq      <= 1'b1;
            s_r.waitreq  <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign avs_readdata    = s_r.rdata;
    assign avs_waitrequest = s_r.waitreq;
    assign tx_request      = s_r.txreq;
    assign halted          = s_r.stop;
    assign sleep_active    = s_r.sleep_act;
    assign irq             = s_r.irq;

endmodule // cef_ctrl

//--- verification/cef_ctrl_props.sv
`timescale 1ns/10ps
`include "cef_defs.svh"

module cef_ctrl_props
    import cef_pkg::*;
#(
    parameter int NUM_MB = 16
)
(
    input wire logic         core_clk,
    input wire logic         rst,
    input wire logic [5:0]   avs_address,
    input wire logic         avs_read,
    input wire logic         avs_write,
    input wire logic [31:0]  avs_writedata,
    input wire logic [3:0]   avs_byteenable,
    input wire logic [31:0]  avs_readdata,
    input wire logic         avs_waitrequest,
    input wire logic         medium_speed,
    input wire logic         hw_standby,
    input wire logic         sw_standby,
    input wire logic         can_receive_pin,
    input wire cef_eng_evt_t eng,
    input wire logic [15:0]  tx_request,
    input wire logic         halted,
    input wire logic         sleep_active,
    input wire logic         irq
);
    // ****************************************
    // Register bus and status checks
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_answer_one_cycle: assert property (s_taken |=> s_answer)
        else $error("answer timing wrong");
    a_upper_lanes_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read lanes not zero");
    a_longword_refused: assert property (avs_read && avs_waitrequest && avs_byteenable == 4'hf
        |=> avs_readdata == 32'h0)
        else $error("longword read not refused");
    a_medium_blocks: assert property (avs_read && avs_waitrequest && medium_speed
        |=> avs_readdata == 32'h0)
        else $error("read allowed in medium speed");
    a_stop_blocks: assert property (avs_read && avs_waitrequest && halted
        && avs_address != `CEF_OFS_STOP |=> avs_readdata == 32'h0)
        else $error("read allowed while stopped");
    a_stop_held: assert property (halted && !(avs_write && avs_waitrequest
        && avs_address == `CEF_OFS_STOP) |=> halted)
        else $error("stop released without write");
    a_stopped_irq: assert property (halted && $past(halted) |-> irq)
        else $error("reset flag not raising irq");
    a_sleep_reset_bit: assert property (avs_read && avs_waitrequest && sleep_active && !halted
        && !medium_speed && avs_address == `CEF_OFS_STATUS && avs_byteenable == 4'h3
        |=> avs_readdata[`CEF_S_RESET])
        else $error("reset status clear in sleep");
endmodule // cef_ctrl_props

bind cef_ctrl cef_ctrl_props #(.NUM_MB(NUM_MB)) u_props (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .medium_speed,
    .hw_standby, .sw_standby, .can_receive_pin, .eng, .tx_request, .halted, .sleep_active, .irq);

//--- verification/cef_eng_model.sv
`timescale 1ns/10ps

module cef_eng_model
    import cef_pkg::*;
(
    input  wire logic   core_clk,
    output cef_eng_evt_t eng,
    output logic        can_receive_pin
);
    // ****************************************
    // Protocol engine and bus line stand-in
    // ****************************************
    initial
    begin
        eng = '0;
        eng.bus_idle = 1'b1;
        can_receive_pin = 1'b1;
    end

    // Kinds: 0 rx, 1 remote, 2 overload, 3 overwrite, 4 tx done, 5..9 error events
    task automatic pulse(input int k, input logic [3:0] mb, input int n);
        cef_eng_evt_t e;
        cef_eng_evt_t idle;
        idle = '0;
        idle.bus_idle = eng.bus_idle;
        idle.tx_busy = eng.tx_busy;
        e = idle;
        e.rx_valid = (k <= 1);
        e.rx_remote = (k == 1);
        e.rx_mb = mb;
        e.tx_mb = mb;
        e.overload = (k == 2);
        e.ovw_valid = (k == 3);
        e.tx_done = (k == 4);
        e.err = (k >= 5) ? cef_err_evt_t'(5'h1 << (9 - k)) : '0;
        // Back-to-back cycles give one event each
        repeat (n) @(posedge core_clk) eng <= e;
        @(posedge core_clk) eng <= idle;
        @(posedge core_clk);
    endtask

    task automatic setpin(input logic v);
        @(posedge core_clk);
        can_receive_pin <= v;
    endtask
endmodule // cef_eng_model

//--- verification/test_cef_ctrl.sv
`timescale 1ns/10ps
`include "cef_defs.svh"
`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("ERROR %s expected %h seen %h", nm, (e), (g)); \
        end \
    end

module test_cef_ctrl
    import cef_pkg::*;
;
    logic         core_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [5:0]   avs_address;
    logic [31:0]  avs_writedata, avs_readdata, got;
    logic [3:0]   avs_byteenable, lo, hi;
    logic         medium_speed, hw_standby, sw_standby, can_receive_pin;
    logic         halted, sleep_active, irq;
    logic [15:0]  tx_request;
    cef_eng_evt_t eng;
    logic [32:0]  exp_q[$], ent;
    int           err_count, cmp_count, n;
    int           kb[5] = '{1, 2, 7, 9, 8}, mk[3] = '{0, 1, 4};

    cef_ctrl #(.NUM_MB(16)) u_dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .medium_speed,
        .hw_standby, .sw_standby, .can_receive_pin, .eng, .tx_request, .halted, .sleep_active, .irq);
    cef_eng_model u_eng (.core_clk, .eng, .can_receive_pin);

    always #2 core_clk = ~core_clk;

    // ****************************************
    // Bus master, read checker and verdict
    // ****************************************
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rdat);
        int t = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && t < 64)
        begin
            @(posedge core_clk);
            t++;
        end
        if (t >= 64)
            err_count++;
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [3:0] be = 4'h3);
        exp_q.push_back({1'b1, e});
        bus(1'b0, a, 32'h0, be, got);
    endtask

    task automatic peek(input logic [5:0] a);
        exp_q.push_back(33'h0);
        bus(1'b0, a, 32'h0, 4'h3, got);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'h3);
        bus(1'b1, a, d, be, got);
    endtask

    task automatic close_out;
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
        begin
            ent = exp_q.pop_front();
            if (ent[32])
                `CHK("readdata", ent[31:0], avs_readdata)
        end
    end

    initial
    begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        close_out();
    end

    initial
    begin
        {core_clk, avs_read, avs_write, medium_speed, hw_standby, sw_standby} = '0;
        {avs_address, avs_writedata, avs_byteenable, err_count, cmp_count} = '0;
        rst = 1'b1;
        void'($urandom(81));
        lo = 4'($urandom % 8);
        hi = 4'(8 + $urandom % 8);
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        `CHK("halted", 1'b1, halted)
        `CHK("irq", 1'b1, irq)
        rd(`CEF_OFS_FLAGS, 32'h0);
        wr(`CEF_OFS_STOP, 32'h0);
        rd(`CEF_OFS_FLAGS, 32'h1);
        rd(`CEF_OFS_GMASK, 32'hffff);
        rd(`CEF_OFS_MBMASK, 32'hffff);
        peek(`CEF_OFS_STATUS);
        `CHK("reset_status", 1'b1, got[`CEF_S_RESET])
        wr(`CEF_OFS_MCTRL, 32'h0);
        wr(`CEF_OFS_FLAGS, 32'h0);
        `CHK("irq", 1'b1, irq)
        wr(`CEF_OFS_FLAGS, 32'h1);
        `CHK("irq", 1'b0, irq)
        wr(`CEF_OFS_GMASK, 32'h0, 4'hf);
        rd(`CEF_OFS_GMASK, 32'hffff);
        rd(`CEF_OFS_GMASK, 32'h0, 4'hf);
        wr(`CEF_OFS_GMASK, 32'h0);
        wr(`CEF_OFS_MBMASK, 32'h0, 4'h1);
        rd(`CEF_OFS_MBMASK, 32'hff00);
        u_eng.pulse(0, 4'h0, 1);
        rd(`CEF_OFS_FLAGS, 32'h2);
        wr(`CEF_OFS_FLAGS, 32'h2);
        for (int k = 0; k < 5; k++)
        begin
            u_eng.pulse(k, lo, 1);
            rd(`CEF_OFS_FLAGS, 1 << kb[k]);
            `CHK("irq", 1'b1, irq)
            wr(`CEF_OFS_FLAGS, 1 << kb[k]);
        end
        foreach (mk[i])
        begin
            u_eng.pulse(mk[i], hi, 1);
            rd(`CEF_OFS_FLAGS, 32'h0);
        end
        wr(`CEF_OFS_GMASK, 32'h80);
        u_eng.pulse(2, lo, 1);
        rd(`CEF_OFS_FLAGS, 32'h80);
        `CHK("irq", 1'b0, irq)
        wr(`CEF_OFS_FLAGS, 32'h80);
        wr(`CEF_OFS_TXREQ, 32'h8);
        `CHK("tx_request", 16'h8, tx_request)
        // Transmit and cancel writes kept 50 us apart
        repeat (12500) @(posedge core_clk);
        got = 32'h8;
        n = 0;
        // Cancel rewritten until it reads back clear
        while (got !== 32'h0 && n < 4)
        begin
            wr(`CEF_OFS_TXCAN, 32'h8);
            peek(`CEF_OFS_TXCAN);
            n++;
        end
        rd(`CEF_OFS_TXREQ, 32'h0);
        rd(`CEF_OFS_FLAGS, 32'h100);
        `CHK("irq", 1'b1, irq)
        wr(`CEF_OFS_FLAGS, 32'h100);
        u_eng.pulse(5, 4'h0, 12);
        rd(`CEF_OFS_TEC, 32'h60);
        rd(`CEF_OFS_FLAGS, 32'h8);
        u_eng.pulse(5, 4'h0, 4);
        rd(`CEF_OFS_FLAGS, 32'h28);
        u_eng.pulse(6, 4'h0, 1);
        rd(`CEF_OFS_TEC, 32'h7f);
        u_eng.pulse(7, 4'h0, 96);
        rd(`CEF_OFS_REC, 32'h60);
        rd(`CEF_OFS_FLAGS, 32'h38);
        u_eng.pulse(8, 4'h0, 1);
        rd(`CEF_OFS_REC, 32'h5f);
        wr(`CEF_OFS_TXREQ, 32'h4);
        u_eng.pulse(5, 4'h0, 17);
        rd(`CEF_OFS_FLAGS, 32'h78);
        wr(`CEF_OFS_FLAGS, 32'h13ff);
        wr(`CEF_OFS_TXCAN, 32'h4);
        rd(`CEF_OFS_TXREQ, 32'h4);
        u_eng.pulse(9, 4'h0, 96);
        rd(`CEF_OFS_REC, 32'h60);
        rd(`CEF_OFS_FLAGS, 32'h10);
        u_eng.pulse(9, 4'h0, 32);
        rd(`CEF_OFS_TXREQ, 32'h0);
        wr(`CEF_OFS_FLAGS, 32'h13ff);
        wr(`CEF_OFS_MCTRL, 32'h20);
        `CHK("sleep_active", 1'b1, sleep_active)
        peek(`CEF_OFS_STATUS);
        `CHK("reset_status", 1'b1, got[`CEF_S_RESET])
        u_eng.setpin(1'b0);
        repeat (3) @(posedge core_clk);
        rd(`CEF_OFS_FLAGS, 32'h1000);
        peek(`CEF_OFS_STATUS);
        `CHK("reset_status", 1'b1, got[`CEF_S_RESET])
        wr(`CEF_OFS_MCTRL, 32'h0);
        u_eng.setpin(1'b1);
        medium_speed <= 1'b1;
        rd(`CEF_OFS_GMASK, 32'h0);
        wr(`CEF_OFS_GMASK, 32'hffff);
        medium_speed <= 1'b0;
        rd(`CEF_OFS_GMASK, 32'h80);
        sw_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        sw_standby <= 1'b0;
        @(posedge core_clk);
        wr(`CEF_OFS_STOP, 32'h0);
        `CHK("irq", 1'b1, irq)
        rd(`CEF_OFS_FLAGS, 32'h1);
        rd(`CEF_OFS_GMASK, 32'hffff);
        wr(`CEF_OFS_GMASK, 32'h0);
        hw_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        hw_standby <= 1'b0;
        @(posedge core_clk);
        wr(`CEF_OFS_STOP, 32'h0);
        rd(`CEF_OFS_GMASK, 32'hffff);
        wr(`CEF_OFS_STOP, 32'h1);
        `CHK("halted", 1'b1, halted)
        rd(`CEF_OFS_MBMASK, 32'h0);
        repeat (4) @(posedge core_clk);
        close_out();
    end
endmodule // test_cef_ctrl
